// file: pkg/nbp_pkg.sv
// nbp_pkg: constants for the protection-command host controller
// assumes the flash is driven through plain pins, software through APB
package nbp_pkg;
  // apb register offsets (one word each)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  // ctrl fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_BYTE_BIT = 1;
  localparam int CTRL_OP_LSB = 4;
  localparam int OP_W = 4;
  // operations
  localparam logic [3:0] OP_ENTER = 4'h0;
  localparam logic [3:0] OP_EXIT = 4'h1;
  localparam logic [3:0] OP_PROG = 4'h2;
  localparam logic [3:0] OP_READ = 4'h3;
  localparam logic [3:0] OP_CLEAR_ALL = 4'h4;
  localparam logic [3:0] OP_UNLOCK_PWD = 4'h5;
  localparam logic [3:0] OP_EXIT_EXT = 4'h6;
  // command codes
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_LOCKREG = 8'h40;
  localparam logic [7:0] CMD_PASSWORD = 8'h60;
  localparam logic [7:0] CMD_NVPROT = 8'hc0;
  localparam logic [7:0] CMD_LOCKBIT = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_CLR1 = 8'h80;
  localparam logic [7:0] CMD_CLR2 = 8'h30;
  localparam logic [7:0] CMD_PWD_UNL1 = 8'h25;
  localparam logic [7:0] CMD_PWD_UNL2 = 8'h03;
  localparam logic [7:0] CMD_PWD_CONF = 8'h29;
  localparam logic [7:0] NV_PROTECT = 8'h00;
  localparam logic [7:0] PWD_LOCKED_DATA = 8'h00;
  // unlock addresses, word and byte mode
  localparam logic [15:0] ADDR_U1_W = 16'h0555;
  localparam logic [15:0] ADDR_U2_W = 16'h02aa;
  localparam logic [15:0] ADDR_U1_B = 16'h0aaa;
  localparam logic [15:0] ADDR_U2_B = 16'h0555;
  // password geometry
  localparam int PWD_PORTIONS_B = 8;
  localparam int PWD_PORTIONS_W = 4;
  // bus-cycle timing
  localparam int CLK_MHZ = 200;
  localparam int TWP_NS = 50;
  localparam int TWP_CYC = (TWP_NS * CLK_MHZ + 999) / 1000;
  localparam int UNLOCK_GAP_US = 6;
  localparam int UNLOCK_GAP_CYC = UNLOCK_GAP_US * CLK_MHZ;
  // status bits
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
endpackage

// file: core/nbp_cycle.sv
// nbp_cycle: one asynchronous flash bus cycle (write or read)
// assumes a pulse start, pins registered, read data sampled via 2 flops
`timescale 1ns/1ps
`default_nettype none
module nbp_cycle #(
  parameter int PULSE_CYC = nbp_pkg::TWP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic wr,
  input wire logic [25:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] dq_in,
  output logic done,
  output logic [15:0] rdata,
  output logic [25:0] a_out,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);
  // pulse + 2 sync stages + 1 recovery
  localparam int CNT_MAX = PULSE_CYC + 3;
  logic [7:0] cnt_q;
  logic busy_q;
  logic [15:0] s1_q, s2_q;
  wire pulse_end = busy_q && (cnt_q == 8'(CNT_MAX));
  wire strobe_on = busy_q && (cnt_q < 8'(PULSE_CYC + 2));
  always_ff @(posedge clk) begin
    s1_q <= dq_in;
    s2_q <= s1_q;
    done <= pulse_end;
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      a_out <= '0;
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      rdata <= 16'h0000;
    end else if (start && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q <= 8'h00;
      a_out <= addr;
      dq_out <= wdata;
      dq_oe <= wr;
      ce_n <= 1'b0;
      oe_n <= wr;
      we_n <= !wr;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == 8'(PULSE_CYC + 1) && !oe_n) rdata <= s2_q;
      if (!strobe_on) begin
        ce_n <= 1'b1;
        oe_n <= 1'b1;
        we_n <= 1'b1;
      end
      if (pulse_end) begin
        busy_q <= 1'b0;
        dq_oe <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: core/nbp_host.sv
// nbp_host: host controller issuing block-protection command sequences
// assumes an APB master on REF_CLK and a parallel NOR flash on the pins
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module nbp_host #(
  parameter int UNLOCK_GAP = nbp_pkg::UNLOCK_GAP_CYC
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [25:0] FL_A,
  input wire logic [15:0] FL_DQ_IN,
  output logic [15:0] FL_DQ_OUT,
  output logic FL_DQ_OE,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic FL_BYTE_N
);
  typedef enum logic [1:0] {NBP_IDLE, NBP_ISSUE, NBP_WAIT} nbp_state_t;
  nbp_state_t st_q;
  logic [3:0] ctrl_op_q;
  logic ctrl_byte_q;
  logic [25:0] addr_q;
  logic [31:0] wdata_q;
  logic [15:0] rdata_q;
  logic refused_q;
  logic mode_q;
  logic [3:0] idx_q;
  logic [3:0] len_q_d;
  logic [15:0] gap_q;
  logic cyc_start, cyc_done;
  logic [15:0] cyc_rdata;
  logic [25:0] seq_a;
  logic [15:0] seq_d;
  logic seq_wr;

  wire apb_wr = PSEL && PENABLE && PWRITE;
  wire sel_ctrl = PADDR == nbp_pkg::REG_CTRL;
  wire sel_addr = PADDR == nbp_pkg::REG_ADDR;
  wire sel_wdata = PADDR == nbp_pkg::REG_WDATA;
  wire sel_stat = PADDR == nbp_pkg::REG_STATUS;
  wire sel_rdata = PADDR == nbp_pkg::REG_RDATA;
  wire mapped = sel_ctrl | sel_addr | sel_wdata | sel_stat | sel_rdata;
  wire busy = st_q != NBP_IDLE;
  wire start_req = apb_wr && sel_ctrl && PWDATA[nbp_pkg::CTRL_START_BIT] && !busy;
  wire [3:0] new_op = PWDATA[nbp_pkg::CTRL_OP_LSB +: nbp_pkg::OP_W];
  // a second unlock too early would be dropped by the flash; refuse it here
  wire unl_early = (new_op == nbp_pkg::OP_UNLOCK_PWD) && (gap_q != 16'h0000);
  // entering while a mode is active would leave block 0 blocked unawares
  wire enter_bad = (new_op == nbp_pkg::OP_ENTER) && mode_q;
  wire refuse = start_req && (unl_early || enter_bad);
  wire go = start_req && !refuse;

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = sel_ctrl ? {24'h000000, ctrl_op_q, 2'b00, ctrl_byte_q, busy}
                : sel_addr ? {6'h00, addr_q}
                : sel_wdata ? wdata_q
                : sel_stat ? {29'h0, mode_q, refused_q, busy}
                : sel_rdata ? {16'h0000, rdata_q}
                : 32'h0000_0000;
  assign FL_BYTE_N = !ctrl_byte_q;

  // unlock-cycle address pair by bus width; upper bits left zero
  wire [15:0] u1 = ctrl_byte_q ? nbp_pkg::ADDR_U1_B : nbp_pkg::ADDR_U1_W;
  wire [15:0] u2 = ctrl_byte_q ? nbp_pkg::ADDR_U2_B : nbp_pkg::ADDR_U2_W;
  wire [3:0] pwd_n = ctrl_byte_q ? 4'(nbp_pkg::PWD_PORTIONS_B) : 4'(nbp_pkg::PWD_PORTIONS_W);
  wire [3:0] portion = idx_q - 4'd2;
  // only 32 password bits carried: byte portions 4..7 repeat 0..3
  wire [15:0] pwd_word = ctrl_byte_q ? {8'h00, wdata_q[8*portion[1:0] +: 8]}
                       : wdata_q[16*portion[0] +: 16];

  // sequence table: cycle idx of operation op
  always_comb begin
    seq_a = 26'h0;
    seq_d = 16'h0000;
    seq_wr = 1'b1;
    len_q_d = 4'd1;
    unique case (ctrl_op_q)
      nbp_pkg::OP_ENTER: begin
        len_q_d = 4'd3;
        seq_a = {10'h0, (idx_q == 4'd1) ? u2 : u1};
        seq_d = (idx_q == 4'd0) ? {8'h00, nbp_pkg::CMD_UNLOCK1}
              : (idx_q == 4'd1) ? {8'h00, nbp_pkg::CMD_UNLOCK2}
              : {8'h00, wdata_q[7:0]};
      end
      nbp_pkg::OP_EXIT: begin
        len_q_d = 4'd2;
        seq_d = (idx_q == 4'd0) ? {8'h00, nbp_pkg::CMD_EXIT1} : {8'h00, nbp_pkg::CMD_EXIT2};
      end
      nbp_pkg::OP_EXIT_EXT: begin
        len_q_d = 4'd4;
        seq_a = (idx_q == 4'd3) ? 26'h0 : {10'h0, (idx_q == 4'd1) ? u2 : u1};
        seq_d = (idx_q == 4'd0) ? {8'h00, nbp_pkg::CMD_UNLOCK1}
              : (idx_q == 4'd1) ? {8'h00, nbp_pkg::CMD_UNLOCK2}
              : (idx_q == 4'd2) ? {8'h00, nbp_pkg::CMD_EXIT1}
              : {8'h00, nbp_pkg::CMD_EXIT2};
      end
      nbp_pkg::OP_PROG: begin
        // one portion or one block per command; address picks it
        len_q_d = 4'd2;
        seq_a = (idx_q == 4'd1) ? addr_q : 26'h0;
        seq_d = (idx_q == 4'd0) ? {8'h00, nbp_pkg::CMD_PROGRAM} : wdata_q[15:0];
      end
      nbp_pkg::OP_READ: begin
        // plain read; the flash returns protection state or portion
        seq_wr = 1'b0;
        seq_a = addr_q;
      end
      nbp_pkg::OP_CLEAR_ALL: begin
        len_q_d = 4'd2;
        seq_d = (idx_q == 4'd0) ? {8'h00, nbp_pkg::CMD_CLR1} : {8'h00, nbp_pkg::CMD_CLR2};
      end
      nbp_pkg::OP_UNLOCK_PWD: begin
        len_q_d = pwd_n + 4'd3;
        seq_a = (idx_q < 4'd2 || idx_q == pwd_n + 4'd2) ? 26'h0 : 26'(portion);
        seq_d = (idx_q == 4'd0) ? {8'h00, nbp_pkg::CMD_PWD_UNL1}
              : (idx_q == 4'd1) ? {8'h00, nbp_pkg::CMD_PWD_UNL2}
              : (idx_q == pwd_n + 4'd2) ? {8'h00, nbp_pkg::CMD_PWD_CONF}
              : pwd_word;
      end
      default: begin
        len_q_d = 4'd1;
        seq_wr = 1'b0;
      end
    endcase
  end
  wire last = idx_q == len_q_d - 4'd1;
  assign cyc_start = st_q == NBP_ISSUE;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      st_q <= NBP_IDLE;
      ctrl_op_q <= nbp_pkg::OP_ENTER;
      ctrl_byte_q <= 1'b0;
      addr_q <= 26'h0;
      wdata_q <= 32'h0;
      rdata_q <= 16'h0;
      refused_q <= 1'b0;
      mode_q <= 1'b0;
      idx_q <= 4'd0;
      gap_q <= 16'h0000;
    end else begin
      if (gap_q != 16'h0000) gap_q <= gap_q - 16'h0001;
      if (apb_wr && sel_addr && !busy) addr_q <= PWDATA[25:0];
      if (apb_wr && sel_wdata && !busy) wdata_q <= PWDATA;
      if (refuse) refused_q <= 1'b1;
      else if (apb_wr && sel_stat && PWDATA[nbp_pkg::ST_REFUSED_BIT]) refused_q <= 1'b0;
      unique case (st_q)
        NBP_IDLE: if (go) begin
          ctrl_op_q <= new_op;
          ctrl_byte_q <= PWDATA[nbp_pkg::CTRL_BYTE_BIT];
          idx_q <= 4'd0;
          st_q <= NBP_ISSUE;
        end
        NBP_ISSUE: st_q <= NBP_WAIT;
        // completion by fixed cycle timing; no data bit is polled
        NBP_WAIT: if (cyc_done) begin
          if (!seq_wr) rdata_q <= cyc_rdata;
          if (last) begin
            st_q <= NBP_IDLE;
            // track mode so the host can refuse a second entry and report it in STATUS
            if (ctrl_op_q == nbp_pkg::OP_ENTER) mode_q <= 1'b1;
            if (ctrl_op_q == nbp_pkg::OP_EXIT || ctrl_op_q == nbp_pkg::OP_EXIT_EXT) mode_q <= 1'b0;
            // covers both retry spacing and unlock completion
            if (ctrl_op_q == nbp_pkg::OP_UNLOCK_PWD) gap_q <= 16'(UNLOCK_GAP);
          end else begin
            idx_q <= idx_q + 4'd1;
            st_q <= NBP_ISSUE;
          end
        end
        default: st_q <= NBP_IDLE;
      endcase
    end
  end

  nbp_cycle u_cycle (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .start(cyc_start),
    .wr(seq_wr),
    .addr(seq_a),
    .wdata(seq_d),
    .dq_in(FL_DQ_IN),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .a_out(FL_A),
    .dq_out(FL_DQ_OUT),
    .dq_oe(FL_DQ_OE),
    .ce_n(FL_CE_N),
    .oe_n(FL_OE_N),
    .we_n(FL_WE_N)
  );
endmodule
`default_nettype wire

// file: verif/nbp_host_monitor.sv
// nbp_host_monitor: port-level checks of the protection host controller
// assumes one clock domain, SYS_RST synchronous and active high
`timescale 1ns/1ps
`default_nettype none
module nbp_host_monitor (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [25:0] FL_A,
  input wire logic [15:0] FL_DQ_OUT,
  input wire logic FL_DQ_OE,
  input wire logic FL_CE_N,
  input wire logic FL_OE_N,
  input wire logic FL_WE_N
);
  wire logic acc = PSEL && PENABLE;
  wire logic mapped = PADDR inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  a_ready_zero_wait: assert property (PREADY)
    else $error("pready low");
  a_slverr_unmapped: assert property (acc && !mapped |-> PSLVERR)
    else $error("no error on unmapped access");
  a_slverr_mapped: assert property (acc && mapped |-> !PSLVERR)
    else $error("error on mapped access");
  a_strobe_exclusive: assert property (!(!FL_WE_N && !FL_OE_N))
    else $error("write and read strobes together");
  a_write_drives_bus: assert property (!FL_WE_N |-> FL_DQ_OE && !FL_CE_N)
    else $error("write strobe without driven bus");
  a_read_frees_bus: assert property (!FL_OE_N |-> !FL_DQ_OE && !FL_CE_N)
    else $error("read strobe while bus driven");
  a_pulse_width: assert property ($fell(FL_WE_N) |-> !FL_WE_N [*8])
    else $error("write pulse too short");
  a_cycle_stable: assert property (!FL_WE_N && !$past(FL_WE_N) |->
      $stable(FL_A) && $stable(FL_DQ_OUT))
    else $error("address or data moved in write pulse");
  a_reset_idle: assert property ($fell(SYS_RST) |->
      FL_CE_N && FL_WE_N && FL_OE_N && !FL_DQ_OE)
    else $error("pins not idle after reset");
endmodule
bind nbp_host nbp_host_monitor nbp_host_monitor_inst (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .FL_A(FL_A), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N),
  .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N));
`default_nettype wire

// file: verif/nbp_flash_model.sv
// nbp_flash_model: behavioural flash answering the protection command sets
// assumes word-mode unlock addresses and host strobes registered on clk
`timescale 1ns/1ps
`default_nettype none
module nbp_flash_model (
  input wire logic clk,
  input wire logic [25:0] a,
  input wire logic [15:0] dq,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [15:0] dq_in
);
  logic [7:0] mode = 8'h00, lreg = 8'h00, wd = 8'h00, rd_q = 8'h00;
  logic [7:0] pwd [4] = '{8'hff, 8'hff, 8'hff, 8'hff};
  logic [15:0] nv = 16'h0000, wa = 16'h0000;
  logic [1:0] ucnt = 2'h0;
  logic we_q = 1'b1, arm = 1'b0, ex = 1'b0, lkb = 1'b1;
  // a protection mode takes over block 0 reads; lock bit hides the password
  wire logic [7:0] rd = (mode == 8'h40) ? lreg : (mode == 8'hc0) ? {7'h0, !nv[a[3:0]]} :
    (mode == 8'h60) ? (lkb ? pwd[a[1:0]] : 8'h00) : ~a[7:0];
  // released bus shows the inverse of the last value, not a held one
  assign dq_in = (!ce_n && !oe_n) ? {8'h00, rd} : {8'hff, ~rd_q};
  always @(posedge clk) begin
    we_q <= we_n;
    if (!we_n && !ce_n) begin
      wa <= a[15:0];
      wd <= dq[7:0];
    end
    if (!oe_n) rd_q <= rd;
    if (we_n && !we_q) begin
      ucnt <= (wd == 8'haa && wa == 16'h0555) ? 2'h1 :
        (ucnt == 2'h1 && wd == 8'h55 && wa == 16'h02aa) ? 2'h2 : 2'h0;
      if (ucnt == 2'h2 && wd == 8'h90) ex <= 1'b1;
      else if (ucnt == 2'h2 && mode == 8'h00) mode <= wd;
      else if (ex) begin
        ex <= 1'b0;
        if (wd == 8'h00) mode <= 8'h00;
      end else if (arm) begin
        arm <= 1'b0;
        if (mode == 8'h40) lreg <= wd;
        if (mode == 8'hc0) nv[wa[3:0]] <= 1'b1;
        if (mode == 8'h50) lkb <= 1'b0;
        if (mode == 8'h60) pwd[wa[1:0]] <= wd;
      end else if (mode != 8'h00 && wd == 8'ha0) arm <= 1'b1;
      else if (mode != 8'h00 && wd == 8'h90) ex <= 1'b1;
      else if (mode == 8'hc0 && wd == 8'h30 && lkb) nv <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// file: verif/nbp_host_test.sv
// nbp_host_test: self-checking bench, APB master plus flash model
// assumes the host answers APB with no wait and polls STATUS for busy
`timescale 1ns/1ps
`default_nettype none
module nbp_host_test;
  logic REF_CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic rchk = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd, v;
  logic [31:0] pw [4];
  logic PREADY, PSLVERR, FL_DQ_OE, FL_CE_N, FL_OE_N, FL_WE_N, FL_BYTE_N;
  logic [25:0] FL_A;
  logic [15:0] FL_DQ_IN, FL_DQ_OUT;
  logic [31:0] expq [$];
  int n_mismatch = 0, num_checks = 0, nwe = 0, seed = 8265, i;
  // short gap keeps the retry scenario brief
  nbp_host #(.UNLOCK_GAP(400)) nbp_host_inst (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FL_A(FL_A), .FL_DQ_IN(FL_DQ_IN),
    .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N),
    .FL_WE_N(FL_WE_N), .FL_BYTE_N(FL_BYTE_N));
  nbp_flash_model nbp_flash_model_inst (.clk(REF_CLK), .a(FL_A), .dq(FL_DQ_OUT),
    .ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N), .dq_in(FL_DQ_IN));
  initial forever #2.5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) if ($fell(FL_WE_N)) nwe <= nwe + 1;
  always @(posedge REF_CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && rchk) check("prdata", expq.pop_front(), PRDATA);
  end
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, input logic c,
      input logic [31:0] e);
    int k;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= wd;
    rchk <= c;
    if (c) expq.push_back(e);
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge REF_CLK);
      if (PREADY === 1'b1) break;
    end
    rd = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    rchk <= 1'b0;
    if (k == 20) n_mismatch++;
    if (k == 20) give_verdict();
  endtask
  // n is the expected count of write strobes, negative skips that check
  task op(input logic [3:0] o, input logic b, input logic [25:0] ad, input logic [31:0] wd,
      input int n);
    int base, k;
    base = nwe;
    apb(1'b1, nbp_pkg::REG_ADDR, {6'h0, ad}, 1'b0, 32'h0);
    apb(1'b1, nbp_pkg::REG_WDATA, wd, 1'b0, 32'h0);
    apb(1'b1, nbp_pkg::REG_CTRL, {24'h0, o, 2'h0, b, 1'b1}, 1'b0, 32'h0);
    rd = 32'h1;
    for (k = 0; k < 300 && rd[0] !== 1'b0; k++) apb(1'b0, nbp_pkg::REG_STATUS, 32'h0, 1'b0, 32'h0);
    if (rd[0] !== 1'b0) n_mismatch++;
    if (rd[0] !== 1'b0) give_verdict();
    if (n >= 0) check("write_strobes", n, nwe - base);
  endtask
  initial begin
    repeat (5) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    apb(1'b0, nbp_pkg::REG_STATUS, 32'h0, 1'b1, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 1'b0, 32'h0);
    op(nbp_pkg::OP_ENTER, 1'b0, 26'h0, 32'h40, 3);
    apb(1'b0, nbp_pkg::REG_STATUS, 32'h0, 1'b1, 32'h4);
    op(nbp_pkg::OP_ENTER, 1'b0, 26'h0, 32'hc0, 0);
    apb(1'b0, nbp_pkg::REG_STATUS, 32'h0, 1'b1, 32'h6);
    apb(1'b1, nbp_pkg::REG_STATUS, 32'h2, 1'b0, 32'h0);
    v = $random(seed) & 32'h3f;
    op(nbp_pkg::OP_PROG, 1'b0, 26'h10, v, -1);
    apb(1'b0, nbp_pkg::REG_ADDR, 32'h0, 1'b1, 32'h10);
    apb(1'b0, nbp_pkg::REG_WDATA, 32'h0, 1'b1, v);
    op(nbp_pkg::OP_READ, 1'b0, 26'h10, 32'h0, 0);
    apb(1'b0, nbp_pkg::REG_RDATA, 32'h0, 1'b1, v);
    op(nbp_pkg::OP_EXIT, 1'b0, 26'h0, 32'h0, 2);
    apb(1'b0, nbp_pkg::REG_STATUS, 32'h0, 1'b1, 32'h0);
    op(nbp_pkg::OP_ENTER, 1'b0, 26'h0, 32'hc0, 3);
    op(nbp_pkg::OP_PROG, 1'b0, 26'h3, 32'h0, -1);
    for (i = 2; i < 4; i++) begin
      op(nbp_pkg::OP_READ, 1'b0, 26'(i), 32'h0, 0);
      apb(1'b0, nbp_pkg::REG_RDATA, 32'h0, 1'b1, (i == 3) ? 32'h0 : 32'h1);
    end
    op(nbp_pkg::OP_CLEAR_ALL, 1'b0, 26'h0, 32'h0, 2);
    op(nbp_pkg::OP_READ, 1'b0, 26'h3, 32'h0, 0);
    apb(1'b0, nbp_pkg::REG_RDATA, 32'h0, 1'b1, 32'h1);
    op(nbp_pkg::OP_EXIT, 1'b0, 26'h0, 32'h0, 2);
    op(nbp_pkg::OP_ENTER, 1'b0, 26'h0, 32'h60, 3);
    for (i = 0; i < 4; i++) begin
      pw[i] = $random(seed) & 32'h3f;
      op(nbp_pkg::OP_PROG, 1'b0, 26'(i), pw[i], -1);
    end
    for (i = 3; i >= 0; i--) begin
      op(nbp_pkg::OP_READ, 1'b0, 26'(i), 32'h0, 0);
      apb(1'b0, nbp_pkg::REG_RDATA, 32'h0, 1'b1, pw[i]);
    end
    v = $random(seed) & 32'h3f3f3f3f;
    op(nbp_pkg::OP_UNLOCK_PWD, 1'b0, 26'h0, v, 7);
    op(nbp_pkg::OP_UNLOCK_PWD, 1'b0, 26'h0, v, 0);
    apb(1'b0, nbp_pkg::REG_STATUS, 32'h0, 1'b1, 32'h6);
    apb(1'b1, nbp_pkg::REG_STATUS, 32'h2, 1'b0, 32'h0);
    repeat (500) @(posedge REF_CLK);
    op(nbp_pkg::OP_UNLOCK_PWD, 1'b1, 26'h0, v, 11);
    check("byte_sel", 32'h0, {31'h0, FL_BYTE_N});
    op(nbp_pkg::OP_EXIT, 1'b0, 26'h0, 32'h0, 2);
    check("byte_sel", 32'h1, {31'h0, FL_BYTE_N});
    op(nbp_pkg::OP_EXIT_EXT, 1'b0, 26'h0, 32'h0, 4);
    give_verdict();
  end
endmodule
`default_nettype wire
